// File: core/echo_ctrl_pkg.sv
package echo_ctrl_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int FRAME_SYNC_HZ = 8_000;
  localparam int BIT_CLOCK_HZ = 200_000;
  localparam int BLANK_US = 100;
  localparam int FRAME_CYCLES = CLK_HZ / FRAME_SYNC_HZ;
  localparam int BIT_HALF_CYCLES = CLK_HZ / (2 * BIT_CLOCK_HZ);
  localparam int BLANK_CYCLES = (BLANK_US * (CLK_HZ / 1_000_000));
  localparam int BUS_WIDTH = 16;
  localparam int BUS_MSB = 15;

  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TX_WORD = 8'h04;
  localparam logic [7:0] ADDR_RX_WORD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL = 8'h10;

  localparam int CTRL_BUS_DRIVE = 0;
  localparam int CTRL_SERIAL_EN = 1;
  localparam int STAT_GAIN = 2;
  localparam int STAT_ATTEN_LSB = 8;
  localparam int STAT_PROC_LSB = 16;

  // Levels in half-dB steps, signed: -20 dBm0, -11.5 dBm0, 8.5 dB
  localparam logic signed [7:0] LEVEL_FLOOR = 8'shD8;
  localparam logic signed [7:0] LEVEL_KNEE = 8'shE9;
  localparam logic [4:0] ATTEN_MAX = 5'h11;

  typedef enum logic [1:0] {
    ST_POWER_DOWN,
    ST_RESET,
    ST_BLANK,
    ST_RUN
  } mode_type;

endpackage

// File: core/echo_ctrl_pins.sv
// Function
// (RULE_01) The cascade bus is 16 bits and its top line carries the word's most significant bit.
// (RULE_02) The cascade bus is floated whenever the device is not putting data on it.
// (RULE_03) Bus data is captured on the falling edge of a parallel transfer flag input.
// (RULE_04) The basic clock is supplied from outside at its nominal rate.
// (RULE_05) A low power-down input puts the device in power-down and ignores all inputs.
// (RULE_06) Power-down floats serial outputs and bus, drives sync and bit clock low, flags high.
// (RULE_07) Leaving power-down performs a reset before normal processing resumes.
// (RULE_08) An 8 kHz frame sync is generated for the codec.
// (RULE_09) A 200 kHz bit clock is generated, ignores reset and is low in power-down.
// (RULE_10) A low reset input resets the device; inputs are ignored 100 us after its release.
// (RULE_11) The basic clock keeps running while the reset input is low.
// (RULE_12) Reset floats serial outputs and bus, drives test low and both flags high.
// (RULE_13) With gain control on, levels from -20 to -11.5 dBm0 compress to -20 dBm0.
// (RULE_14) The gain-control input is driven high to enable and tied low on a slave.
// (RULE_15) Gain control is sampled on the interrupt falling edge or on reset release.
// (RULE_16) A falling edge on the interrupt input starts one processing cycle.
// (RULE_17) The power-down exit reset uses the same output states and blanking as a pin reset.
`timescale 1ns/100ps
module echo_ctrl_pins (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_down_n,
  input  wire logic        device_reset_n,
  input  wire logic        process_int_n,
  input  wire logic        gain_control_en,
  input  wire logic [1:0]  parallel_transfer_flag_in,
  input  wire logic [15:0] cascade_parallel_bus_in,
  output logic [15:0]      cascade_parallel_bus_out,
  output logic             cascade_parallel_bus_oe,
  input  wire logic        receive_serial_in,
  output logic             send_serial_out,
  output logic             send_serial_oe,
  output logic             receive_serial_out,
  output logic             receive_serial_oe,
  output logic             frame_sync_out,
  output logic             bit_clock_out,
  output logic             transfer_flag_out_a,
  output logic             transfer_flag_out_b,
  output logic             test_out,
  output logic             load_detect_out,
  output logic             master_clock_out,
  output logic             oscillator_out,
  output logic             process_start,
  output logic [4:0]       gain_atten
);

  echo_ctrl_pkg::mode_type mode;
  echo_ctrl_pkg::mode_type next_mode;

  logic [11:0]             frame_count;
  logic [6:0]              bit_count;
  logic [11:0]             blank_count;
  logic                    int_prev;
  logic [1:0]              flag_prev;
  logic                    rst_prev;
  logic                    gain_latched;
  logic [15:0]             tx_word;
  logic [15:0]             rx_word;
  logic [1:0]              control;
  logic signed [7:0]       recv_level;
  logic [15:0]             proc_cycles;

  wire                     run = (mode == echo_ctrl_pkg::ST_RUN);
  wire                     pd = ~power_down_n;
  wire                     frame_wrap = (frame_count == 12'(echo_ctrl_pkg::FRAME_CYCLES - 1));
  wire                     bit_wrap = (bit_count == 7'(echo_ctrl_pkg::BIT_HALF_CYCLES - 1));
  wire                     blank_done = (blank_count == 12'(echo_ctrl_pkg::BLANK_CYCLES - 1));
  wire                     int_fall = run && int_prev && !process_int_n;
  wire                     flag_fall = run && |(flag_prev & ~parallel_transfer_flag_in);
  wire                     rst_rise = !rst_prev && device_reset_n;
  wire                     driving = run && control[echo_ctrl_pkg::CTRL_BUS_DRIVE];
  wire                     apb_access = psel && penable && !pready;
  // Writes take effect only at the edge that completes the access
  wire                     apb_wr = psel && penable && pready && pwrite;
  wire                     hit_ctrl = (paddr == echo_ctrl_pkg::ADDR_CONTROL);
  wire                     hit_tx = (paddr == echo_ctrl_pkg::ADDR_TX_WORD);
  wire                     hit_rx = (paddr == echo_ctrl_pkg::ADDR_RX_WORD);
  wire                     hit_stat = (paddr == echo_ctrl_pkg::ADDR_STATUS);
  wire                     hit_level = (paddr == echo_ctrl_pkg::ADDR_LEVEL);
  wire                     mapped = hit_ctrl | hit_tx | hit_rx | hit_stat | hit_level;
  wire                     wr_ctrl = apb_wr && hit_ctrl;
  wire                     wr_tx = apb_wr && hit_tx;
  wire                     wr_level = apb_wr && hit_level;
  wire                     gain_sample = int_fall ||
                           (rst_rise && !pd && mode == echo_ctrl_pkg::ST_RESET);
  wire                     sync_window =
                           (frame_count < 12'(2 * echo_ctrl_pkg::BIT_HALF_CYCLES));

  // Compression law in half-dB steps
  wire signed [7:0]        over_floor = recv_level - echo_ctrl_pkg::LEVEL_FLOOR;
  wire [4:0]               law_atten = (recv_level < echo_ctrl_pkg::LEVEL_FLOOR) ? 5'h00 :
                                       (recv_level > echo_ctrl_pkg::LEVEL_KNEE)
                                       ? echo_ctrl_pkg::ATTEN_MAX : over_floor[4:0];
  wire [4:0]               next_atten = gain_latched ? law_atten : 5'h00; // RULE_13

  wire [31:0]              status_word = {16'(proc_cycles),
                                          3'h0, gain_atten,
                                          5'h00, gain_latched, mode};
  wire [31:0]              read_mux = hit_ctrl  ? {30'h0, control} :
                                      hit_tx    ? {16'h0, tx_word} :
                                      hit_rx    ? {16'h0, rx_word} :
                                      hit_stat  ? status_word :
                                      hit_level ? {{24{recv_level[7]}}, recv_level} : 32'h0;

  // Power-down wins over everything; both exits go through blanking
  always_comb begin
    next_mode = mode;
    if (pd) begin // RULE_05
      next_mode = echo_ctrl_pkg::ST_POWER_DOWN;
    end else begin
      case (mode)
        echo_ctrl_pkg::ST_POWER_DOWN: next_mode = echo_ctrl_pkg::ST_RESET; // RULE_07
        echo_ctrl_pkg::ST_RESET: begin
          if (device_reset_n) begin
            next_mode = echo_ctrl_pkg::ST_BLANK; // RULE_10
          end
        end
        echo_ctrl_pkg::ST_BLANK: begin
          if (!device_reset_n) begin
            next_mode = echo_ctrl_pkg::ST_RESET;
          end else if (blank_done) begin
            next_mode = echo_ctrl_pkg::ST_RUN;
          end
        end
        echo_ctrl_pkg::ST_RUN: begin
          if (!device_reset_n) begin
            next_mode = echo_ctrl_pkg::ST_RESET;
          end
        end
        default: next_mode = echo_ctrl_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode <= echo_ctrl_pkg::ST_RESET;
    end else begin
      mode <= next_mode; // RULE_17
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || mode != echo_ctrl_pkg::ST_BLANK) begin
      blank_count <= 12'h000;
    end else if (!blank_done) begin
      blank_count <= blank_count + 12'h001; // RULE_10
    end
  end

  // Codec timing runs through device reset, stops in power-down
  always_ff @(posedge sys_clk) begin
    if (!resetn || pd) begin
      frame_count <= 12'h000;
    end else begin
      frame_count <= frame_wrap ? 12'h000 : frame_count + 12'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || pd) begin
      bit_count <= 7'h00;
      bit_clock_out <= 1'b0; // RULE_06
    end else begin
      bit_count <= bit_wrap ? 7'h00 : bit_count + 7'h01;
      if (bit_wrap) begin
        bit_clock_out <= ~bit_clock_out; // RULE_09
      end
    end
  end

  // Sync is one bit-clock period wide at the frame start
  always_ff @(posedge sys_clk) begin
    if (!resetn || pd) begin
      frame_sync_out <= 1'b0; // RULE_06
    end else begin
      frame_sync_out <= sync_window; // RULE_08
    end
  end

  // Free-running clock outputs are unaffected by power-down and device reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      master_clock_out <= 1'b0;
      oscillator_out <= 1'b1;
    end else begin
      master_clock_out <= ~master_clock_out;
      oscillator_out <= master_clock_out;
    end
  end

  // Edges only count in run, so a level held through blanking never fires
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      int_prev <= 1'b1;
    end else begin
      int_prev <= process_int_n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flag_prev <= 2'h3;
    end else begin
      flag_prev <= parallel_transfer_flag_in;
    end
  end

  // Power-down reads as reset high, so its exit alone is no release edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rst_prev <= 1'b1;
    end else begin
      rst_prev <= device_reset_n | pd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      process_start <= 1'b0;
      proc_cycles <= 16'h0000;
    end else begin
      process_start <= int_fall; // RULE_16
      if (int_fall) begin
        proc_cycles <= proc_cycles + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gain_latched <= 1'b0;
    end else if (gain_sample) begin
      gain_latched <= gain_control_en; // RULE_15
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gain_atten <= 5'h00;
    end else begin
      gain_atten <= next_atten;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_word <= 16'h0000;
    end else if (flag_fall && !driving) begin
      rx_word <= cascade_parallel_bus_in; // RULE_03 RULE_01
    end
  end

  // Bus and serial drivers: floated unless running and enabled
  always_ff @(posedge sys_clk) begin
    if (!resetn || pd || !run) begin
      cascade_parallel_bus_oe <= 1'b0; // RULE_02 RULE_06 RULE_12
      cascade_parallel_bus_out <= 16'h0000;
    end else begin
      cascade_parallel_bus_oe <= driving; // RULE_02
      cascade_parallel_bus_out <= tx_word; // RULE_01
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || pd || !run) begin
      send_serial_oe <= 1'b0; // RULE_06 RULE_12
      receive_serial_oe <= 1'b0;
      send_serial_out <= 1'b0;
      receive_serial_out <= 1'b0;
    end else begin
      send_serial_oe <= control[echo_ctrl_pkg::CTRL_SERIAL_EN];
      receive_serial_oe <= control[echo_ctrl_pkg::CTRL_SERIAL_EN];
      // No echo path here, so the send line only shows idle zeros
      send_serial_out <= 1'b0;
      receive_serial_out <= receive_serial_in;
    end
  end

  // Flags idle high so a released cascade never sees a false falling edge
  always_ff @(posedge sys_clk) begin
    if (!resetn || pd || !run) begin
      transfer_flag_out_a <= 1'b1; // RULE_06 RULE_12
      transfer_flag_out_b <= 1'b1;
    end else begin
      transfer_flag_out_a <= ~driving;
      transfer_flag_out_b <= ~driving;
    end
  end

  // Test output holds in power-down and is low in reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      test_out <= 1'b0;
    end else if (pd) begin
      test_out <= test_out; // RULE_06
    end else if (mode == echo_ctrl_pkg::ST_RESET || !device_reset_n) begin
      test_out <= 1'b0; // RULE_12
    end else if (run && frame_wrap) begin
      test_out <= ~test_out;
    end
  end

  // Load detect ignores device reset and holds in power-down
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      load_detect_out <= 1'b1;
    end else if (!pd) begin
      load_detect_out <= !frame_wrap; // RULE_12
    end
  end

  // One wait state keeps prdata and pready straight from flops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !mapped;
      prdata <= (apb_access && !pwrite) ? read_mux : 32'h0000_0000;
    end
  end

  // Writes to unmapped offsets fall through every decode and are lost
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      control <= 2'h0;
    end else if (wr_ctrl) begin
      control <= pwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_word <= 16'h0000;
    end else if (wr_tx) begin
      tx_word <= pwdata[echo_ctrl_pkg::BUS_MSB:0];
    end
  end

  // Level resets to the floor, where the law gives no attenuation
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      recv_level <= echo_ctrl_pkg::LEVEL_FLOOR;
    end else if (wr_level) begin
      recv_level <= pwdata[7:0];
    end
  end

endmodule

// File: verification/echo_ctrl_pins_sva.sv
`timescale 1ns/100ps
module echo_ctrl_pins_sva (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down_n,
  input wire logic device_reset_n,
  input wire logic process_int_n,
  input wire logic cascade_parallel_bus_oe,
  input wire logic send_serial_oe,
  input wire logic receive_serial_oe,
  input wire logic frame_sync_out,
  input wire logic bit_clock_out,
  input wire logic transfer_flag_out_a,
  input wire logic transfer_flag_out_b,
  input wire logic test_out,
  input wire logic load_detect_out,
  input wire logic master_clock_out,
  input wire logic oscillator_out,
  input wire logic process_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic        parked;
  logic [1:0]  live;
  logic [11:0] quiet;
  logic [11:0] fs_cnt;
  logic        fs_ok;
  assign parked = !cascade_parallel_bus_oe && !send_serial_oe && !receive_serial_oe
                  && transfer_flag_out_a && transfer_flag_out_b;
  always_ff @(posedge sys_clk) begin
    if (!resetn) live <= 2'h0;
    else if (live != 2'h3) live <= live + 2'h1;
  end
  // Time since every reset source let go; saturates so it never wraps into blanking
  always_ff @(posedge sys_clk) begin
    if (!resetn || !device_reset_n || !power_down_n) quiet <= 12'h000;
    else if (quiet != 12'hFFF) quiet <= quiet + 12'h001;
  end
  // First frame after power-down is not timed: its phase is free
  always_ff @(posedge sys_clk) begin
    if (!resetn || !power_down_n) fs_ok <= 1'b0;
    else if ($rose(frame_sync_out)) fs_ok <= 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if ($rose(frame_sync_out)) fs_cnt <= 12'h000;
    else fs_cnt <= fs_cnt + 12'h001;
  end
  property p_pd_out;
    !power_down_n [*4] |-> parked && !frame_sync_out && !bit_clock_out;
  endproperty
  a_pd_out: assert property (p_pd_out) else $error("power-down pin states wrong");
  property p_pd_hold;
    !power_down_n [*5] |-> $stable(test_out) && $stable(load_detect_out);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("held outputs moved");
  property p_clk_run;
    live == 2'h3 |-> master_clock_out != $past(master_clock_out)
                     && oscillator_out == $past(master_clock_out);
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock outputs stalled");
  property p_rst_out;
    (!device_reset_n && power_down_n) [*3] |-> parked && !test_out;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset pin states wrong");
  property p_blank;
    process_start |-> quiet >= 12'(echo_ctrl_pkg::BLANK_CYCLES);
  endproperty
  a_blank: assert property (p_blank) else $error("start during blanking");
  property p_start;
    $fell(process_int_n) && quiet > 12'h834 |-> ##[1:2] process_start;
  endproperty
  a_start: assert property (p_start) else $error("interrupt edge lost");
  property p_pulse;
    process_start |=> !process_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_bclk;
    $rose(bit_clock_out) |-> ##49 (bit_clock_out || !power_down_n)
                             ##1 (!bit_clock_out || !power_down_n);
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock half period wrong");
  property p_sync;
    $rose(frame_sync_out) && fs_ok |-> fs_cnt == 12'(echo_ctrl_pkg::FRAME_CYCLES - 1);
  endproperty
  a_sync: assert property (p_sync) else $error("frame sync period wrong");
  property p_apb;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("register access not answered");
  property p_ld;
    $fell(load_detect_out) && power_down_n |=> load_detect_out && $rose(frame_sync_out);
  endproperty
  a_ld: assert property (p_ld) else $error("load detect not one cycle before sync");
  c_start: cover property (process_start);
  c_drive: cover property ($rose(cascade_parallel_bus_oe));
  c_err: cover property (pslverr);
  c_pd: cover property ($fell(power_down_n));
endmodule
bind echo_ctrl_pins echo_ctrl_pins_sva u_sva (.sys_clk(sys_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .power_down_n(power_down_n), .device_reset_n(device_reset_n),
  .process_int_n(process_int_n), .cascade_parallel_bus_oe(cascade_parallel_bus_oe),
  .send_serial_oe(send_serial_oe), .receive_serial_oe(receive_serial_oe),
  .frame_sync_out(frame_sync_out), .bit_clock_out(bit_clock_out),
  .transfer_flag_out_a(transfer_flag_out_a), .transfer_flag_out_b(transfer_flag_out_b),
  .test_out(test_out), .load_detect_out(load_detect_out),
  .master_clock_out(master_clock_out), .oscillator_out(oscillator_out),
  .process_start(process_start));

// File: verification/cascade_partner.sv
`timescale 1ns/100ps
module cascade_partner (
  input  wire logic        sys_clk,
  input  wire logic        send,
  input  wire logic [15:0] word,
  input  wire logic        dut_oe,
  input  wire logic [15:0] dut_word,
  output logic             flag_n,
  output logic [15:0]      bus_in
);
  logic [15:0] held = 16'h0000;
  logic [1:0]  hold_cnt = 2'h0;
  always @(posedge sys_clk) begin
    if (send) begin
      held <= word;
      hold_cnt <= 2'h2;
    end
    else if (hold_cnt != 2'h0) hold_cnt <= hold_cnt - 2'h1;
  end
  // Flag idles high like its pull-up; falls with the word already on the bus
  assign flag_n = (hold_cnt == 2'h0);
  // Released bus shows the inverse so a stale word cannot pass as captured
  assign bus_in = dut_oe ? dut_word : (flag_n ? ~held : held);
endmodule

// File: verification/echo_ctrl_pins_test.sv
`timescale 1ns/100ps
module echo_ctrl_pins_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd;
  logic        rdy, err, er, oe, fl, so, ro, fs, bc, fa, fb, tst, st;
  logic        pd_n = 1'b1;
  logic        dr_n = 1'b1;
  logic        int_n = 1'b1;
  logic        gain_in = 1'b1;
  logic        rx_in = 1'b1;
  logic        sso, rso;
  logic        snd = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] bi, bo;
  logic [4:0]  att;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          starts = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (st === 1'b1) starts++;
  echo_ctrl_pins dut (.sys_clk(clk), .resetn(rst_n), .psel(psel), .penable(pen),
    .pwrite(pwr), .paddr(pa), .pwdata(pwd), .prdata(prd), .pready(rdy), .pslverr(err),
    .power_down_n(pd_n), .device_reset_n(dr_n), .process_int_n(int_n),
    .gain_control_en(gain_in), .parallel_transfer_flag_in({fb, fl}),
    .cascade_parallel_bus_in(bi), .cascade_parallel_bus_out(bo),
    .cascade_parallel_bus_oe(oe), .receive_serial_in(rx_in), .send_serial_out(sso),
    .send_serial_oe(so), .receive_serial_out(rso), .receive_serial_oe(ro),
    .frame_sync_out(fs), .bit_clock_out(bc), .transfer_flag_out_a(fa),
    .transfer_flag_out_b(fb), .test_out(tst), .load_detect_out(), .master_clock_out(),
    .oscillator_out(), .process_start(st), .gain_atten(att));
  cascade_partner far (.sys_clk(clk), .send(snd), .word(wd), .dut_oe(oe),
    .dut_word(bo), .flag_n(fl), .bus_in(bi));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic xfer(input logic [15:0] w);
    @(posedge clk);
    wd <= w;
    snd <= 1'b1;
    @(posedge clk);
    snd <= 1'b0;
    cyc(4);
  endtask
  task automatic t_reg();
    apb(0, echo_ctrl_pkg::ADDR_LEVEL, 0);
    chk(rd, 32'hFFFFFFD8);
    apb(0, 8'h14, 0);
    chk(er, 1);
    chk(rd, 0);
  endtask
  task automatic t_blank();
    int t, s;
    logic b;
    t = 0;
    dr_n <= 1'b0;
    cyc(4);
    chk({oe, so, ro, tst, fa, fb}, 6'b000011);
    repeat (100) begin
      b = bc;
      @(posedge clk);
      t += (bc !== b);
    end
    chk(t, 2);
    dr_n <= 1'b1;
    cyc(100);
    s = starts;
    int_n <= 1'b0;
    cyc(5);
    chk(starts, s);
    apb(0, echo_ctrl_pkg::ADDR_STATUS, 0);
    chk(rd[1:0], 2);
    int_n <= 1'b1;
    cyc(2000);
    apb(0, echo_ctrl_pkg::ADDR_STATUS, 0);
    chk(rd[1:0], 3);
    chk(rd[2], 1);
    t = rd[31:16];
    int_n <= 1'b0;
    cyc(4);
    chk(starts, s + 1);
    apb(0, echo_ctrl_pkg::ADDR_STATUS, 0);
    chk(rd[31:16], t + 1);
    int_n <= 1'b1;
  endtask
  task automatic t_gain();
    logic [7:0] lv [5] = '{8'hCE, 8'hD8, 8'hE1, 8'hE9, 8'hF6};
    logic [4:0] ex [5] = '{5'h00, 5'h00, 5'h09, 5'h11, 5'h11};
    gain_in <= 1'b0;
    foreach (lv[i]) begin
      apb(1, echo_ctrl_pkg::ADDR_LEVEL, {{24{lv[i][7]}}, lv[i]});
      cyc(3);
      chk(att, ex[i]);
    end
    int_n <= 1'b0;
    cyc(4);
    chk(att, 0);
    int_n <= 1'b1;
    gain_in <= 1'b1;
  endtask
  task automatic t_cascade();
    apb(1, echo_ctrl_pkg::ADDR_CONTROL, 0);
    xfer(16'h8001);
    apb(0, echo_ctrl_pkg::ADDR_RX_WORD, 0);
    chk(rd, 32'h8001);
    apb(1, echo_ctrl_pkg::ADDR_TX_WORD, 32'hA5C3);
    apb(1, echo_ctrl_pkg::ADDR_CONTROL, 1);
    cyc(3);
    chk({oe, bo, fa, fb}, {1'b1, 16'hA5C3, 2'b00});
    xfer(16'h1234);
    apb(0, echo_ctrl_pkg::ADDR_RX_WORD, 0);
    chk(rd, 32'h8001);
    apb(1, echo_ctrl_pkg::ADDR_CONTROL, 0);
    cyc(3);
    chk({oe, fa, fb}, 3'b011);
  endtask
  task automatic t_pd();
    logic t;
    int s;
    apb(1, echo_ctrl_pkg::ADDR_CONTROL, 3);
    rx_in <= 1'b0;
    cyc(3);
    chk({so, ro, sso, rso}, 4'b1100);
    pd_n <= 1'b0;
    cyc(4);
    t = tst;
    s = starts;
    int_n <= 1'b0;
    cyc(10);
    chk({oe, so, ro, fs, bc, fa, fb, tst}, {5'b00000, 2'b11, t});
    chk(starts, s);
    int_n <= 1'b1;
    pd_n <= 1'b1;
    cyc(5);
    apb(0, echo_ctrl_pkg::ADDR_STATUS, 0);
    chk(rd[1:0], 2);
    cyc(2100);
    apb(0, echo_ctrl_pkg::ADDR_STATUS, 0);
    chk(rd[1:0], 3);
  endtask
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(2100);
    t_reg();
    t_blank();
    t_gain();
    t_cascade();
    t_pd();
    end_of_test();
  end
  // Tests need about 6.6k cycles; six times that means a hang
  initial begin
    #2_000_000;
    mismatches++;
    end_of_test();
  end
endmodule
